// ===== src/qas_consts.svh
`ifndef QAS_CONSTS_SVH
`define QAS_CONSTS_SVH

// ----------------------------------------
// conversion cycle, counted in serial-clock edges
// ----------------------------------------
`define QAS_CONV_EDGES      5'h10
`define QAS_HOLD_FALL       5'h04
`define QAS_FIRST_DATA_FALL 5'h05
`define QAS_LAST_DATA_FALL  5'h0C
`define QAS_CTRL_LAST_RISE  4'h7

// ----------------------------------------
// control word layout
// ----------------------------------------
`define QAS_CTRL_BITS       8
`define QAS_CHAN_HI         4
`define QAS_CHAN_LO         3

// ----------------------------------------
// reset values
// ----------------------------------------
`define QAS_CTRL_RST        8'h00
`define QAS_CHAN_RST        2'h0
`define QAS_RESULT_RST      8'h00
`define QAS_PIN_RST         3'h1

`endif

// ===== src/qas_pin_sync.sv
`timescale 1ns/1ps

module qas_pin_sync #(
  parameter int              WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             sys_clk_i,  // system clock
  input  wire logic             resetn_i,   // synchronous reset, active low
  input  wire logic [WIDTH-1:0] pin_i,      // asynchronous pin levels
  output logic      [WIDTH-1:0] level_o     // filtered levels
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // ----------------------------------------
  // a change is taken only once stages two and three agree
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        next_level[g] = (stage2[g] == stage3[g]) ? stage3[g] : level[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      level  <= RST_VAL;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign level_o = level;

endmodule

// ===== src/qas_pkg.sv
package qas_pkg;

  // power-down covers both the deselected frame and the gap between conversions
  typedef enum logic [1:0] {
    st_pwrdn,
    st_track,
    st_hold
  } qas_state_t;

endpackage

// ===== src/qas_sequencer.sv
`timescale 1ns/1ps
`include "qas_consts.svh"

module qas_sequencer (
  input  wire logic       sys_clk_i,    // 250 MHz system clock
  input  wire logic       resetn_i,     // synchronous reset, active low
  input  wire logic       cs_n_i,       // frame select pin, active low
  input  wire logic       sclk_i,       // serial clock pin
  input  wire logic       din_i,        // serial control input pin
  input  wire logic [7:0] conv_code_i,  // code from the converter core
  output logic            dout_o,       // serial result output
  output logic            dout_oe_o,    // result output enable, high drives
  output logic      [1:0] chan_sel_o,   // analog input mux select
  output logic            track_o,      // sampling switch in track
  output logic            hold_o,       // hold and convert phase
  output logic            power_down_o, // core powered down
  output logic      [7:0] ctrl_word_o   // control register contents
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pins_f;
  logic       cs_f;
  logic       sclk_f;
  logic       din_f;

  qas_pin_sync #(
    .WIDTH   (3),
    .RST_VAL (`QAS_PIN_RST)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     ({din_i, sclk_i, cs_n_i}),
    .level_o   (pins_f)
  );

  assign cs_f   = pins_f[0];
  assign sclk_f = pins_f[1];
  assign din_f  = pins_f[2];

  // ----------------------------------------
  // edge detection on the gated serial clock
  // ----------------------------------------
  logic cs_d;
  logic sclk_d;
  logic next_cs_d;
  logic next_sclk_d;
  logic int_fall;
  logic int_rise;

  always_comb begin
    next_cs_d   = cs_f;
    next_sclk_d = sclk_f;
    // a select fall with the clock low is the first falling edge
    int_fall = (cs_d & ~cs_f & ~sclk_f) | (sclk_d & ~sclk_f & ~cs_f);
    int_rise = ~sclk_d & sclk_f & ~cs_f;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cs_d   <= 1'h1;
      sclk_d <= 1'h0;
    end else begin
      cs_d   <= next_cs_d;
      sclk_d <= next_sclk_d;
    end
  end

  // ----------------------------------------
  // conversion phase, driven by falling edges
  // ----------------------------------------
  qas_pkg::qas_state_t state;
  qas_pkg::qas_state_t next_state;
  logic [4:0]          fall_cnt;
  logic [4:0]          next_fall_cnt;
  logic [4:0]          fall_inc;
  logic [1:0]          chan;
  logic [1:0]          next_chan;
  logic [7:0]          result_q;
  logic [7:0]          next_result_q;
  logic                dout;
  logic                next_dout;
  logic [7:0]          ctrl_q;

  always_comb begin
    next_state    = state;
    next_fall_cnt = fall_cnt;
    next_chan     = chan;
    next_result_q = result_q;
    next_dout     = dout;
    fall_inc      = 5'(fall_cnt + 5'h01);
    if (cs_f) begin
      next_state    = qas_pkg::st_pwrdn;
      next_fall_cnt = 5'h00;
      next_dout     = 1'h0;
    end else if (int_fall) begin
      case (state)
        qas_pkg::st_pwrdn: begin
          // fall after the sixteenth rise starts the next conversion
          next_state    = qas_pkg::st_track;
          next_fall_cnt = 5'h01;
          next_chan     = ctrl_q[`QAS_CHAN_HI:`QAS_CHAN_LO];
          next_dout     = 1'h0;
        end
        qas_pkg::st_track: begin
          next_fall_cnt = fall_inc;
          next_dout     = 1'h0;
          if (fall_inc == `QAS_HOLD_FALL) begin
            next_state    = qas_pkg::st_hold;
            // core output is taken as-is: 8-bit straight binary
            next_result_q = conv_code_i;
          end
        end
        qas_pkg::st_hold: begin
          next_fall_cnt = fall_inc;
          if (fall_inc >= `QAS_FIRST_DATA_FALL && fall_inc <= `QAS_LAST_DATA_FALL) begin
            next_dout = result_q[3'(`QAS_LAST_DATA_FALL - fall_inc)];
          end else begin
            next_dout = 1'h0;
          end
          if (fall_inc == `QAS_CONV_EDGES) begin
            next_state = qas_pkg::st_pwrdn;
          end
        end
        default: begin
          next_state = qas_pkg::st_pwrdn;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state    <= qas_pkg::st_pwrdn;
      fall_cnt <= 5'h00;
      chan     <= `QAS_CHAN_RST;
      result_q <= `QAS_RESULT_RST;
      dout     <= 1'h0;
    end else begin
      state    <= next_state;
      fall_cnt <= next_fall_cnt;
      chan     <= next_chan;
      result_q <= next_result_q;
      dout     <= next_dout;
    end
  end

  // ----------------------------------------
  // control input capture, driven by rising edges
  // ----------------------------------------
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic [6:0] shift_q;
  logic [6:0] next_shift_q;
  logic [7:0] next_ctrl_q;

  always_comb begin
    next_rise_cnt = rise_cnt;
    next_shift_q  = shift_q;
    next_ctrl_q   = ctrl_q;
    if (cs_f) begin
      next_rise_cnt = 4'h0;
    end else if (int_rise) begin
      // counter wraps each sixteen rises, so every conversion captures anew
      next_rise_cnt = 4'(rise_cnt + 4'h1);
      if (rise_cnt <= `QAS_CTRL_LAST_RISE) begin
        next_shift_q = {shift_q[5:0], din_f};
      end
      if (rise_cnt == `QAS_CTRL_LAST_RISE) begin
        next_ctrl_q = {shift_q, din_f};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rise_cnt <= 4'h0;
      shift_q  <= 7'h00;
      ctrl_q   <= `QAS_CTRL_RST;
    end else begin
      rise_cnt <= next_rise_cnt;
      shift_q  <= next_shift_q;
      ctrl_q   <= next_ctrl_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dout_o       = dout;
  assign dout_oe_o    = ~cs_f;
  assign chan_sel_o   = chan;
  assign track_o      = (state == qas_pkg::st_track);
  assign hold_o       = (state == qas_pkg::st_hold);
  assign power_down_o = (state == qas_pkg::st_pwrdn);
  assign ctrl_word_o  = ctrl_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_dout_released_idle:
    assert property (cs_n_i [*6] |-> !dout_oe_o)
    else $error("result output driven while deselected");

  a_pwrdn_when_idle:
    assert property (cs_f |=> power_down_o && !track_o && !hold_o)
    else $error("core not powered down while deselected");

  a_track_three_clk:
    assert property ($rose(hold_o) |-> fall_cnt == `QAS_HOLD_FALL && $past(track_o))
    else $error("hold entered at the wrong falling edge");

  a_gap_after_hold:
    assert property ($fell(hold_o) && !cs_f |-> power_down_o && $past(fall_cnt) == 5'h0F)
    else $error("conversion gap not entered after sixteenth fall");

  a_dout_zero_out:
    assert property (!(fall_cnt inside {[`QAS_FIRST_DATA_FALL:`QAS_LAST_DATA_FALL]}) |-> !dout_o)
    else $error("result output not zero outside data window");

  a_dout_msb_first:
    assert property ($changed(fall_cnt) && fall_cnt == `QAS_FIRST_DATA_FALL |-> dout_o == result_q[7])
    else $error("first data bit is not the MSB");

  a_chan_from_ctrl:
    assert property ($rose(track_o) |-> chan_sel_o == $past(ctrl_q[`QAS_CHAN_HI:`QAS_CHAN_LO]))
    else $error("channel not taken from control register");

  a_ctrl_capture:
    assert property (int_rise && rise_cnt == `QAS_CTRL_LAST_RISE |=> ctrl_word_o == {$past(shift_q), $past(din_f)})
    else $error("control word not loaded on eighth rise");

  a_track_on_select:
    assert property ($fell(cs_f) && !sclk_f |=> track_o)
    else $error("select fall with clock low did not start tracking");

  c_back_to_back: cover property (fall_cnt == `QAS_CONV_EDGES ##[1:200] track_o);
  c_start_clk_high: cover property ($fell(cs_f) && sclk_f ##[1:100] track_o);
  c_full_result: cover property (hold_o && fall_cnt == `QAS_LAST_DATA_FALL);

endmodule

// ===== verification/qas_host_model.sv
`timescale 1ns/1ps

module qas_host_model (
  input  wire logic       sys_clk_i,    // system clock, pacing only
  input  wire logic       dout_i,       // resolved result pin
  input  wire logic       dout_oe_i,    // result enable seen
  input  wire logic [1:0] chan_sel_i,   // mux select seen
  input  wire logic       track_i,      // track phase seen
  input  wire logic       hold_i,       // hold phase seen
  input  wire logic       power_down_i, // power state seen
  input  wire logic [7:0] ctrl_word_i,  // control register seen
  output logic            cs_n_o,       // frame select, active low
  output logic            sclk_o,       // serial clock
  output logic            din_o,        // control word bit
  output logic      [7:0] conv_code_o   // converter core result
);
  // channel expected in the current conversion; input zero after power-up
  int chan = 0;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    conv_code_o = 8'h00;
  end

  task automatic pace(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // ----------------------------------------
  // one frame of whole 16-clock conversions
  // ----------------------------------------
  task automatic frame(input int n_conv, input bit idle_high, input int half,
                       input logic [7:0] words[$], input logic [7:0] codes[$]);
    sclk_o = idle_high;
    pace(half);
    cs_n_o = 1'b0;
    if (idle_high) pace(half);
    for (int c = 0; c < n_conv; c++) begin
      conv_code_o = codes[c];
      for (int k = 1; k <= 16; k++) begin
        if (k > 1 || c > 0 || idle_high) sclk_o = 1'b0;
        din_o = (k <= 8) ? words[c][8-k] : ~din_o;
        pace(half);
        tb_top.check("dout_oe", 8'h01, 8'(dout_oe_i));
        tb_top.check("track", 8'(k <= 3), 8'(track_i));
        tb_top.check("hold", 8'(k >= 4 && k <= 15), 8'(hold_i));
        tb_top.check("power_down", 8'(k == 16), 8'(power_down_i));
        tb_top.check("chan_sel", 8'(chan), 8'(chan_sel_i));
        tb_top.check("dout", (k >= 5 && k <= 12) ? 8'(codes[c][12-k]) : 8'h00, 8'(dout_i));
        // the core may move on once held; the result must not follow it
        if (k == 5) conv_code_o = ~codes[c];
        sclk_o = 1'b1;
        pace(half);
        if (k == 8) tb_top.check("ctrl_word", words[c], ctrl_word_i);
      end
      chan = int'(words[c][4:3]);
    end
    cs_n_o = 1'b1;
    // clock keeps toggling while deselected; it must be gated off
    for (int t = 0; t < 5; t++) begin
      pace(half);
      sclk_o = ~sclk_o;
    end
    pace(half);
    tb_top.check("dout_oe_idle", 8'h00, 8'(dout_oe_i));
    tb_top.check("power_down_idle", 8'h01, 8'(power_down_i));
    tb_top.check("track_idle", 8'h00, 8'(track_i));
    tb_top.check("ctrl_kept", words[n_conv-1], ctrl_word_i);
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic       sys_clk_i;
  logic       resetn_i;
  logic       cs_n;
  logic       sclk;
  logic       din;
  logic [7:0] conv_code;
  logic       dout;
  logic       dout_oe;
  logic       dout_pin;
  logic [1:0] chan_sel;
  logic       track;
  logic       hold;
  logic       power_down;
  logic [7:0] ctrl_word;
  int         miscompares = 0;
  int         comparisons = 0;
  int         tgl = 0;
  logic [7:0] lfsr = 8'h5C;
  logic [7:0] words[$];
  logic [7:0] codes[$];

  // released pin shows a changing pattern, never a stale bit
  assign dout_pin = dout_oe ? dout : tgl[0];

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) tgl <= tgl + 1;

  qas_sequencer dut_u (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .cs_n_i       (cs_n),
    .sclk_i       (sclk),
    .din_i        (din),
    .conv_code_i  (conv_code),
    .dout_o       (dout),
    .dout_oe_o    (dout_oe),
    .chan_sel_o   (chan_sel),
    .track_o      (track),
    .hold_o       (hold),
    .power_down_o (power_down),
    .ctrl_word_o  (ctrl_word)
  );

  qas_host_model host_u (
    .sys_clk_i    (sys_clk_i),
    .dout_i       (dout_pin),
    .dout_oe_i    (dout_oe),
    .chan_sel_i   (chan_sel),
    .track_i      (track),
    .hold_i       (hold),
    .power_down_i (power_down),
    .ctrl_word_i  (ctrl_word),
    .cs_n_o       (cs_n),
    .sclk_o       (sclk),
    .din_o        (din),
    .conv_code_o  (conv_code)
  );

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    check("power_down_rst", 8'h01, 8'(power_down));
    check("dout_oe_rst", 8'h00, 8'(dout_oe));
    check("chan_rst", 8'h00, 8'(chan_sel));
    resetn_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    // frames of one to three conversions; both clock idle levels, two speeds
    for (int f = 0; f < 4; f++) begin
      words.delete();
      codes.delete();
      for (int c = 0; c < 3; c++) begin
        lfsr = lfsr_next(lfsr);
        words.push_back((lfsr & 8'hE7) | 8'(((f + c) % 4) << 3));
        lfsr = lfsr_next(lfsr);
        codes.push_back(lfsr);
      end
      host_u.frame(f % 3 + 1, f[0], 8 + 4 * f[0], words, codes);
    end
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    miscompares++;
    complete_run();
  end
endmodule
